/* File: hdl/ifp_regs.sv */
// interrupt flag status 3/5 and priority control 8 register slice
`timescale 1ns/1ps
// Summary of operation
// RQ1: all three registers sit at data-space addresses, read and written directly.
// RQ2: each flag is software read/write, hardware settable, cleared on reset.
// RQ3: bit 14 of flag status 3 records a calendar clock request.
// RQ4: bit 2 of flag status 3 records a second I2C master event.
// RQ5: bit 1 of flag status 3 records a second I2C slave event.
// RQ6: bit 0 of flag status 5 records a low-power wake-up request.
// RQ7: unimplemented bits of both flag registers always read zero.
// RQ8: priority control 8 holds two 3-bit fields resetting to 100, rest zero.
// RQ9: software clears flags by writing zero; a same-cycle hardware set wins.
module ifp_regs
  import ifp_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  // data-space access
  input  wire logic [ADDR_W-1:0] BUS_ADDR,
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  input  wire logic [DATA_W-1:0] BUS_WDATA,
  output logic      [DATA_W-1:0] BUS_RDATA,
  output logic                   BUS_RVALID,
  // event sources
  input  wire ifp_evt_t          EVT,
  // state toward the arbiter
  output ifp_flags_t             FLAGS,
  output logic      [PRIO_W-1:0] SPI_EVENT_PRIO,
  output logic      [PRIO_W-1:0] SPI_AUX_PRIO
);

  // flag table, indexed in the bit order of ifp_flags_t (calendar is top)
  localparam int unsigned NUM_FLAGS = $bits(ifp_flags_t);

  // bit position of each flag inside its status register
  localparam int unsigned FLAG_POS [NUM_FLAGS-1:0] = '{
    BIT_CALENDAR_CLOCK,
    BIT_I2C2_MASTER,
    BIT_I2C2_SLAVE,
    BIT_LOW_POWER_WAKE
  };

  // which status register holds each flag: 1 for status 5, 0 for status 3
  localparam logic FLAG_IN_FS5 [NUM_FLAGS-1:0] = '{
    1'h0,
    1'h0,
    1'h0,
    1'h1
  };

  // registered state and its next values
  logic [NUM_FLAGS-1:0] flag_q;
  logic [NUM_FLAGS-1:0] flag_d;
  logic [PRIO_W-1:0]    spi_event_prio_q;
  logic [PRIO_W-1:0]    spi_event_prio_d;
  logic [PRIO_W-1:0]    spi_aux_prio_q;
  logic [PRIO_W-1:0]    spi_aux_prio_d;
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;
  logic                 rvalid_q;
  logic                 rvalid_d;

  // address decode
  logic                 hit_fs3;
  logic                 hit_fs5;
  logic                 hit_pc8;
  logic                 wr_fs3;
  logic                 wr_fs5;
  logic                 wr_pc8;

  // per-flag controls
  logic [NUM_FLAGS-1:0] evt_vec;
  logic [NUM_FLAGS-1:0] flag_wr;
  logic [NUM_FLAGS-1:0] flag_wbit;

  // register views and read selection
  logic [DATA_W-1:0]    fs3_view;
  logic [DATA_W-1:0]    fs5_view;
  logic [DATA_W-1:0]    pc8_view;
  logic [DATA_W-1:0]    rd_mux;

  // exact word address match; nothing else in data space is claimed
  assign hit_fs3 = (BUS_ADDR == ADDR_FLAG_STATUS_3);  // see RQ1
  assign hit_fs5 = (BUS_ADDR == ADDR_FLAG_STATUS_5);  // see RQ1
  assign hit_pc8 = (BUS_ADDR == ADDR_PRIO_CONTROL_8); // see RQ1

  // write strobes per register
  assign wr_fs3 = BUS_WR && hit_fs3; // see RQ1
  assign wr_fs5 = BUS_WR && hit_fs5; // see RQ1
  assign wr_pc8 = BUS_WR && hit_pc8; // see RQ1

  // event strobes laid out in flag order
  assign evt_vec = EVT;

  // one slice per flag: write select, next value and storage
  for (genvar k = 0; k < NUM_FLAGS; k++) begin : g_flag

    // software reaches the flag through its own status register only
    assign flag_wr[k] = FLAG_IN_FS5[k] ? wr_fs5 : wr_fs3; // see RQ2

    // the written bit sits at the flag's own position
    assign flag_wbit[k] = BUS_WDATA[FLAG_POS[k]]; // see RQ2

    // event set wins over a software write of zero in the same cycle
    assign flag_d[k] = evt_vec[k] |
        (flag_wr[k] ? flag_wbit[k] : flag_q[k]); // see RQ3, RQ4, RQ5, RQ6

    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        flag_q[k] <= FLAG_RESET; // see RQ2
      end else begin
        flag_q[k] <= flag_d[k]; // see RQ2
      end
    end

  end

  // priority fields take the written value, otherwise hold
  always_comb begin
    spi_event_prio_d = spi_event_prio_q;
    spi_aux_prio_d   = spi_aux_prio_q;
    if (wr_pc8) begin
      spi_event_prio_d = BUS_WDATA[LSB_SPI_EVENT_PRIO +: PRIO_W]; // see RQ8
      spi_aux_prio_d   = BUS_WDATA[LSB_SPI_AUX_PRIO +: PRIO_W];   // see RQ8
    end
  end

  // second SPI event priority
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spi_event_prio_q <= PRIO_RESET; // see RQ8
    end else begin
      spi_event_prio_q <= spi_event_prio_d; // see RQ8
    end
  end

  // second SPI auxiliary priority
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spi_aux_prio_q <= PRIO_RESET; // see RQ8
    end else begin
      spi_aux_prio_q <= spi_aux_prio_d; // see RQ8
    end
  end

  // status 3 view: only its own flags, all other bits low
  always_comb begin
    fs3_view = DATA_ZERO;
    for (int unsigned i = 0; i < NUM_FLAGS; i++) begin
      if (!FLAG_IN_FS5[i]) begin
        fs3_view[FLAG_POS[i]] = flag_q[i]; // see RQ3, RQ4, RQ5, RQ7
      end
    end
  end

  // status 5 view: only its own flag, all other bits low
  always_comb begin
    fs5_view = DATA_ZERO;
    for (int unsigned i = 0; i < NUM_FLAGS; i++) begin
      if (FLAG_IN_FS5[i]) begin
        fs5_view[FLAG_POS[i]] = flag_q[i]; // see RQ6, RQ7
      end
    end
  end

  // priority view: two fields, the gaps and upper bits low
  always_comb begin
    pc8_view = DATA_ZERO;
    pc8_view[LSB_SPI_EVENT_PRIO +: PRIO_W] = spi_event_prio_q; // see RQ8
    pc8_view[LSB_SPI_AUX_PRIO +: PRIO_W]   = spi_aux_prio_q;   // see RQ8
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (BUS_ADDR)
      ADDR_FLAG_STATUS_3: begin
        rd_mux = fs3_view; // see RQ1
      end
      ADDR_FLAG_STATUS_5: begin
        rd_mux = fs5_view; // see RQ1
      end
      ADDR_PRIO_CONTROL_8: begin
        rd_mux = pc8_view; // see RQ1
      end
      default: begin
        rd_mux = DATA_ZERO;
      end
    endcase
  end

  // a read answers one cycle later; data holds until the next read
  always_comb begin
    rvalid_d = BUS_RD;
    rdata_d  = rdata_q;
    if (BUS_RD) begin
      rdata_d = rd_mux; // see RQ1
    end
  end

  // read answer strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'h0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // read data
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= DATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from the registers
  assign BUS_RDATA      = rdata_q;
  assign BUS_RVALID     = rvalid_q;
  assign FLAGS          = ifp_flags_t'(flag_q);
  assign SPI_EVENT_PRIO = spi_event_prio_q;
  assign SPI_AUX_PRIO   = spi_aux_prio_q;

  // the flag store keeps its packed order fixed against the struct
  // so that the arbiter sees the same bit layout as the views above

endmodule // ifp_regs

/* File: hdl/ifp_pkg.sv */
// package for the interrupt flag and priority register slice
package ifp_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PRIO_W = 3;

  // data-space byte addresses of the three registers
  localparam logic [ADDR_W-1:0] ADDR_FLAG_STATUS_3   = 16'h0088;
  localparam logic [ADDR_W-1:0] ADDR_FLAG_STATUS_5   = 16'h008C;
  localparam logic [ADDR_W-1:0] ADDR_PRIO_CONTROL_8  = 16'h00B0;

  // bit positions in irq_flag_status_3
  localparam int unsigned BIT_CALENDAR_CLOCK = 14;
  localparam int unsigned BIT_I2C2_MASTER    = 2;
  localparam int unsigned BIT_I2C2_SLAVE     = 1;
  // bit position in irq_flag_status_5
  localparam int unsigned BIT_LOW_POWER_WAKE = 0;
  // field low bits in irq_priority_control_8
  localparam int unsigned LSB_SPI_EVENT_PRIO = 4;
  localparam int unsigned LSB_SPI_AUX_PRIO   = 0;

  localparam logic              FLAG_RESET = 1'b0;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 16'h0000;

  // hardware event strobes, one cycle each
  typedef struct packed {
    logic calendar_clock;
    logic i2c2_master;
    logic i2c2_slave;
    logic low_power_wakeup;
  } ifp_evt_t;

  // stored flag bits
  typedef struct packed {
    logic calendar_clock_irq_flag;
    logic second_i2c_master_event_flag;
    logic second_i2c_slave_event_flag;
    logic low_power_wakeup_flag;
  } ifp_flags_t;

endpackage

/* File: bench/ifp_regs_properties.sv */
// assertion checker for the flag and priority register slice
`timescale 1ns/1ps
module ifp_regs_chk import ifp_pkg::*; (
  input wire logic              CLK, ARST_N, BUS_WR, BUS_RD, BUS_RVALID,
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic [DATA_W-1:0] BUS_WDATA, BUS_RDATA,
  input wire ifp_evt_t          EVT,
  input wire ifp_flags_t        FLAGS,
  input wire logic [PRIO_W-1:0] SPI_EVENT_PRIO, SPI_AUX_PRIO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_rd; BUS_RD ##1 BUS_RVALID; endsequence
  AST_RD: assert property (BUS_RD |-> s_rd) else $error("no answer");
  AST_NORD: assert property (!BUS_RD |=> !BUS_RVALID)
    else $error("stray answer");
  AST_SET: assert property (|EVT |=> (FLAGS & $past(EVT)) == $past(EVT))
    else $error("event lost");
  AST_FS3: assert property (BUS_RVALID && $past(BUS_ADDR) == 16'h0088 |->
    BUS_RDATA == {1'b0, $past(FLAGS[3]), 11'h0, $past(FLAGS[2:1]), 1'b0})
    else $error("status 3 read");
  AST_FS5: assert property (BUS_RVALID && $past(BUS_ADDR) == 16'h008C |->
    BUS_RDATA == {15'h0, $past(FLAGS[0])}) else $error("status 5 read");
  AST_PRD: assert property (BUS_RVALID && $past(BUS_ADDR) == 16'h00B0 |->
    BUS_RDATA == {9'h0, $past(SPI_EVENT_PRIO), 1'b0, $past(SPI_AUX_PRIO)})
    else $error("prio read");
  AST_PWR: assert property (BUS_WR && BUS_ADDR == 16'h00B0 |=>
    {SPI_EVENT_PRIO, SPI_AUX_PRIO} == $past({BUS_WDATA[6:4], BUS_WDATA[2:0]}))
    else $error("prio write");
  AST_CLR: assert property (BUS_WR && BUS_ADDR == 16'h0088 && BUS_WDATA == 0
    && !EVT[3] |=> !FLAGS[3]) else $error("flag not cleared");
endmodule // ifp_regs_chk
bind ifp_regs ifp_regs_chk i_ifp_regs_chk (.*);

/* File: bench/ifp_regs_tb.sv */
// self-checking bench for the flag and priority register slice
`timescale 1ns/1ps
module ifp_regs_tb import ifp_pkg::*;;
  logic CLK = 0, ARST_N = 0, BUS_WR = 0, BUS_RD = 0, BUS_RVALID;
  logic [15:0] BUS_ADDR = 0, BUS_WDATA = 0, BUS_RDATA;
  ifp_evt_t EVT = '0;
  ifp_flags_t FLAGS;
  logic [2:0] SPI_EVENT_PRIO, SPI_AUX_PRIO;
  int errors = 0, checks_done = 0;
  logic [15:0] rows [5][3] = '{'{16'h00B0, 16'hFFFF, 16'h0077},
    '{16'h0088, 16'hFFFF, 16'h4006}, '{16'h008C, 16'hFFFF, 16'h0001},
    '{16'h0088, 16'h0000, 16'h0000}, '{16'h0090, 16'hFFFF, 16'h0000}};
  ifp_regs i_ifp_regs (.*);
  task automatic chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(posedge CLK) #1 {BUS_WR, BUS_ADDR, BUS_WDATA} = {1'b1, a, d};
    @(posedge CLK) #1 BUS_WR = 0;
  endtask
  task automatic rd(input logic [15:0] a, e);
    @(posedge CLK) #1 {BUS_RD, BUS_ADDR} = {1'b1, a};
    @(posedge CLK) #1 BUS_RD = 0;
    chk({15'h0, BUS_RVALID}, 16'h0001);
    chk(BUS_RDATA, e);
  endtask
  task automatic chk_state(input logic [3:0] f, input logic [2:0] pe, pa);
    checks_done++;
    if ({FLAGS, SPI_EVENT_PRIO, SPI_AUX_PRIO} !== {f, pe, pa}) begin
      errors++;
      $display("Error at %0t: state %h %h %h", $time, FLAGS,
               SPI_EVENT_PRIO, SPI_AUX_PRIO);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial forever #2.5 CLK = ~CLK;
  initial begin
    #5000;
    errors++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge CLK);
    #1 ARST_N = 1;
    rd(16'h00B0, 16'h0044);
    rd(16'h0088, 16'h0000);
    chk_state(4'h0, 3'h4, 3'h4);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    chk_state(4'h1, 3'h7, 3'h7);
    $display("table test done");
    // all events land in the same cycle as a clearing write
    @(posedge CLK) #1 {EVT, BUS_WR, BUS_ADDR, BUS_WDATA} = {4'hF, 17'h10088, 16'h0};
    @(posedge CLK) #1 {EVT, BUS_WR} = 0;
    rd(16'h0088, 16'h4006);
    rd(16'h008C, 16'h0001);
    wr(16'h008C, 16'h0000);
    rd(16'h008C, 16'h0000);
    chk_state(4'hE, 3'h7, 3'h7);
    $display("event test done");
    @(posedge CLK) #1 ARST_N = 0;
    @(posedge CLK) #1 ARST_N = 1;
    chk_state(4'h0, 3'h4, 3'h4);
    rd(16'h00B0, 16'h0044);
    $display("mid-run reset test done");
    close_out;
  end
endmodule // ifp_regs_tb
